// [tb/pin_side_model.sv]
// far side: timer and serial outputs, pin levels, port c pin 2
// assumes the bench sets the outside level of each undriven pin
module pin_side_model (
  input wire logic aclk,
  input wire logic [7:0] e_out,
  input wire logic [7:0] e_oe,
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] e_ext,
  input wire logic [7:0] a_ext,
  input wire logic c2_ext,
  output logic [7:0] e_in,
  output logic [7:0] a_in,
  output logic c2,
  output logic ct1,
  output logic st,
  output logic tx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph = 1'b0;
  // function levels swap each cycle so both levels reach the pins
  always @(posedge aclk) ph <= ~ph;
  assign ct1 = ph;
  assign st = ~ph;
  assign tx = ~ph;
  // a driven pin reads its driver, an undriven one the outside level
  assign e_in = (e_oe & e_out) | (~e_oe & e_ext);
  assign a_in = (a_oe & a_out) | (~a_oe & a_ext);
  assign c2 = c2_ext;
endmodule // pin_side_model

// [tb/port_e_pin_mux_assertions.sv]
// checker: selector-driven routing, reset state and wake of the pin mux
// assumes address and data of a write are offered together
module port_e_pin_mux_assertions #(
  parameter [7:0] IN_SRC_MASK = 8'hFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [7:0] port_e_in,
  input wire logic [7:0] port_e_out,
  input wire logic [7:0] port_e_oe,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_a_oe,
  input wire logic port_c_pin2,
  input wire logic compact_timer1_output,
  input wire logic standard_timer_output,
  input wire logic serial_tx,
  input wire logic serial_rx_in,
  input wire logic compact_timer1_ext_clock,
  input wire logic standard_timer_ext_clock,
  input wire logic standard_timer_capture_in,
  input wire logic periodic_timer0_capture_in,
  input wire logic periodic_timer1_capture_in,
  input wire logic sleeping,
  input wire logic wake
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lo_m, hi_m, iss_m, wen_m;
  logic hit;
  assign hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_wstrb[0];
  // shadow of the selectors; split aw/w offers are not tracked
  always @(posedge aclk) begin
    if (!aresetn) begin
      lo_m <= 8'h00;
      hi_m <= 8'h00;
      iss_m <= 8'h00;
      wen_m <= 8'h00;
    end else if (hit) begin
      case (s_axi_awaddr[5:0])
        6'h00: lo_m <= s_axi_wdata[7:0];
        6'h04: hi_m <= s_axi_wdata[7:0];
        6'h08: iss_m <= s_axi_wdata[7:0] & IN_SRC_MASK;
        6'h1C: wen_m <= s_axi_wdata[7:0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_fall;
    sleeping && |(wen_m & $past(port_a_in) & ~port_a_in);
  endsequence
  a_rx_source: assert property (serial_rx_in ==
    (iss_m[7:6] == 2'h0 ? port_c_pin2 : port_e_in[1])) else $error("rx src");
  a_pt1_capture: assert property (periodic_timer1_capture_in ==
    (iss_m[5:4] == 2'h0 ? port_a_in[3] : port_a_in[4])) else $error("pt1");
  a_pt0_capture: assert property (periodic_timer0_capture_in ==
    (iss_m[3:2] == 2'h0 ? port_a_in[0] : port_a_in[1])) else $error("pt0");
  a_st_capture: assert property (standard_timer_capture_in ==
    (iss_m[1:0] == 2'h0 ? port_e_in[5] : port_e_in[6])) else $error("st");
  a_ext_clocks: assert property (compact_timer1_ext_clock ==
    port_e_in[2] && standard_timer_ext_clock == port_e_in[4])
    else $error("ext clock");
  a_lo_functions: assert property (lo_m[1:0] == 2'h1 |->
    port_e_out[0] == serial_tx && (lo_m[3:2] != 2'h1 || !port_e_oe[1]) &&
    (lo_m[7:6] != 2'h1 || port_e_out[3] == compact_timer1_output))
    else $error("low functions");
  a_hi_functions: assert property (hi_m[5:4] == 2'h1 |->
    port_e_out[6] == standard_timer_output &&
    (hi_m[3:2] != 2'h1 || port_e_out[5] == standard_timer_output))
    else $error("high functions");
  a_reset_quiet: assert property ($rose(aresetn) |->
    port_e_oe == 8'h00 && port_a_oe == 8'h00) else $error("reset oe");
  a_wake_pulse: assert property (s_fall |=> wake)
    else $error("no wake");
endmodule // port_e_pin_mux_assertions

bind port_e_pin_mux port_e_pin_mux_assertions #(
  .IN_SRC_MASK(IN_SRC_MASK)) chk (.*);

// [tb/port_e_pin_mux_test.sv]
// self-checking bench for the port e pin mux over axi4-lite
// assumes the pin-side model and the bound checker
module port_e_pin_mux_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MASK = 8'hFD;
  localparam logic [7:0] DATA = 8'h58;
  logic aclk = 1'b0, aresetn = 1'b0, sleeping = 1'b0, c2_ext = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] e_ext = 8'h02, a_ext = 8'h09;
  logic awready, wready, bvalid, arready, rvalid, rx, wake;
  logic [1:0] bresp, rresp, r, c;
  logic [31:0] rdata, d, v;
  logic [7:0] e_out, e_oe, a_out, a_oe, e_in, a_in, m;
  logic c2, ct1, st, tx, ct1_clk, st_clk, st_cap, pt0_cap, pt1_cap, w;
  int n_fail = 0, n_checks = 0;
  // inputs beside expected input-source readback (masked)
  logic [15:0] rows [4] = '{16'h0000, 16'h5555, 16'hAAA8, 16'hFFFD};

  always #20 aclk = ~aclk;

  port_e_pin_mux #(.IN_SRC_MASK(MASK)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_e_in(e_in),
    .port_e_out(e_out), .port_e_oe(e_oe), .port_a_in(a_in),
    .port_a_out(a_out), .port_a_oe(a_oe), .port_c_pin2(c2),
    .compact_timer1_output(ct1), .standard_timer_output(st),
    .serial_tx(tx), .serial_rx_in(rx), .compact_timer1_ext_clock(ct1_clk),
    .standard_timer_ext_clock(st_clk), .standard_timer_capture_in(st_cap),
    .periodic_timer0_capture_in(pt0_cap),
    .periodic_timer1_capture_in(pt1_cap), .sleeping(sleeping), .wake(wake));

  pin_side_model far (.aclk(aclk), .e_out(e_out), .e_oe(e_oe),
    .a_out(a_out), .a_oe(a_oe), .e_ext(e_ext), .a_ext(a_ext),
    .c2_ext(c2_ext), .e_in(e_in), .a_in(a_in), .c2(c2), .ct1(ct1),
    .st(st), .tx(tx));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] s, e, input string n);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, dw, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dw;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] dr,
                    output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    dr = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [31:0] a, e);
    rd(a, d, r);
    chk(d, e, "rdata");
  endtask

  task test_done;
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    test_done;
  end

  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    wr(32'h10, {24'h0, DATA}, r);
    wr(32'h14, 32'h0, r);
    foreach (rows[i]) begin
      v = {24'h0, rows[i][15:8]};
      m = rows[i][7:0];
      c = v[1:0];
      wr(32'h0, v, r);
      wr(32'h4, v, r);
      wr(32'h8, v, r);
      rchk(32'h0, v);
      rchk(32'h4, v);
      rchk(32'h8, {24'h0, m});
      repeat (2) begin
        @(negedge aclk);
        chk(e_out[3], c == 2'h1 ? ct1 : DATA[3], "pin3");
        chk(e_out[2], DATA[2], "pin2");
        chk(e_oe[1], c != 2'h1, "pin1 oe");
        chk(e_out[0], c == 2'h1 ? tx : DATA[0], "pin0");
        chk(e_out[7], DATA[7], "pin7");
        chk(e_out[6], c == 2'h1 ? st : DATA[6], "pin6");
        chk(e_out[5], c == 2'h1 ? st : DATA[5], "pin5");
        chk(e_out[4], DATA[4], "pin4");
        chk(ct1_clk, e_in[2], "ct1 clk");
        chk(st_clk, e_in[4], "st clk");
        chk(rx, c == 2'h0 ? c2 : e_in[1], "rx");
        chk(pt1_cap, c == 2'h0 ? a_in[3] : a_in[4], "pt1");
        chk(pt0_cap, c == 2'h0 ? a_in[0] : a_in[1], "pt0");
        chk(st_cap, m[1:0] == 2'h0 ? e_in[5] : e_in[6], "st");
      end
    end
    // reset in mid-run, with the selector and port e registers dirty
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(e_oe, 8'h00, "e_oe");
    chk(a_oe, 8'h00, "a_oe");
    rchk(32'h24, 32'hFF);
    for (int i = 0; i < 6; i++) rchk(32'(4 * i), i < 3 ? 0 : 32'hFF);
    wr(32'h28, 32'hFF, r);
    chk(r, 2'h2, "bresp");
    rd(32'h28, d, r);
    chk(r, 2'h2, "rresp");
    chk(d, 32'h0, "rdata");
    wr(32'h18, 32'h27, r);
    rchk(32'h10, 32'h7F);
    wr(32'h18, 32'h00, r);
    rchk(32'h0C, 32'hFE);
    chk(a_out, 8'hFE, "a_out");
    rchk(32'h18, 32'h0);
    // pin 3 falls first but only pin 0 may wake the part
    wr(32'h1C, 32'h01, r);
    sleeping <= 1'b1;
    a_ext <= 8'h01;
    w = 1'b0;
    repeat (4) @(negedge aclk) w = w | wake;
    chk(w, 1'b0, "wake");
    @(posedge aclk);
    a_ext <= 8'h00;
    w = 1'b0;
    repeat (4) @(negedge aclk) w = w | wake;
    chk(w, 1'b1, "wake");
    wr(32'h24, 32'h0F, r);
    chk(a_oe, 8'hF0, "a_oe");
    test_done;
  end
endmodule // port_e_pin_mux_test

// [verilog/port_e_mux_defines.vh]
// register offsets, field positions, reset values for the port e pin mux
// assumes inclusion by bare name from the design files under verilog/
`ifndef PORT_E_MUX_DEFINES_VH
`define PORT_E_MUX_DEFINES_VH

// register byte offsets on the axi4-lite slave
`define OFS_PE_LOW_SEL 6'h00
`define OFS_PE_HIGH_SEL 6'h04
`define OFS_IN_SRC_SEL 6'h08
`define OFS_PORT_A_DATA 6'h0C
`define OFS_PORT_A_DIR 6'h24
`define OFS_PORT_E_DATA 6'h10
`define OFS_PORT_E_DIR 6'h14
`define OFS_BIT_OP 6'h18
`define OFS_WAKE_EN 6'h1C
`define OFS_STATUS 6'h20
// highest mapped offset; anything above answers with an error
`define OFS_LAST 6'h24

// selector code that picks the alternate function
`define CODE_ALT 2'h1
`define CODE_FIRST 2'h0

// field positions of the input-source register
`define ISS_RX_LSB 6
`define ISS_PT1_LSB 4
`define ISS_PT0_LSB 2
`define ISS_ST_LSB 0

// reset values
`define RST_SEL 8'h00
`define RST_PORT 8'hFF

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [verilog/port_e_pin_mux.v]
// port e pin-function mux, input-source selector and port a/e i/o registers
// assumes an axi4-lite master on aclk and pins synchronous to aclk
//
// How it works
// - pin 3 code 01 drives compact timer output
// - pin 2 always general i/o, feeds clock
// - pin 1 code 01 turns the pin to input; serial receive takes pin1 by receive source
// - pin 0 code 01 drives serial transmit
// - pin 7 always general i/o
// - pin 6 code 01 drives standard timer output
// - pin 5 code 01 drives standard timer output
// - pin 4 general i/o, feeds standard clock
// - receive source: 00 port c, else pin1
// - periodic timer 1 capture: a3 or a4
// - periodic timer 0 capture: a0 or a1
// - standard capture: e5 or e6
// - masked input-source bits read zero; function selectors keep all bits
// - port data and direction reset high
// - bit set/clear is read-modify-write of byte
// - enabled port a falling edge wakes sleep
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`include "port_e_mux_defines.vh"

module port_e_pin_mux #(
  parameter [7:0] IN_SRC_MASK = 8'hFF
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port_e_in,
  output wire [7:0] port_e_out,
  output wire [7:0] port_e_oe,
  input wire [7:0] port_a_in,
  output wire [7:0] port_a_out,
  output wire [7:0] port_a_oe,
  input wire port_c_pin2,
  input wire compact_timer1_output,
  input wire standard_timer_output,
  input wire serial_tx,
  output wire serial_rx_in,
  output wire compact_timer1_ext_clock,
  output wire standard_timer_ext_clock,
  output wire standard_timer_capture_in,
  output wire periodic_timer0_capture_in,
  output wire periodic_timer1_capture_in,
  input wire sleeping,
  output wire wake
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] port_e_low_function_select_reg;
  reg [7:0] port_e_high_function_select_reg;
  reg [7:0] input_source_select_reg;
  reg [7:0] port_a_data_reg;
  reg [7:0] port_a_dir_reg;
  reg [7:0] port_e_data_reg;
  reg [7:0] port_e_dir_reg;
  reg [7:0] wake_en_reg;
  reg [7:0] port_e_data_next;
  reg [7:0] port_e_dir_next;
  reg [7:0] port_a_data_next;
  reg [7:0] port_a_dir_next;

  // write channel holding flags; address and data may arrive in any order
  reg aw_held_reg;
  reg w_held_reg;
  reg [5:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire [5:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire wr_fire;

  // byte-lane merge of a write into an eight-bit register
  function [7:0] lane0;
    input [7:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      lane0 = strb[0] ? data[7:0] : old;
    end
  endfunction

  // single bit set or clear on a whole byte; bit[3]=1 sets, [2:0] index
  function [7:0] bit_op;
    input [7:0] old;
    input [3:0] op;
    begin
      bit_op = old;
      bit_op[op[2:0]] = op[3];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // axi write path

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr[5:0];
  assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  assign wr_fire = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) &&
                   (w_held_reg || (s_axi_wvalid && s_axi_wready));

  // hold whichever half arrives first, answer once both are in
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 6'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr[5:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr > `OFS_LAST) || (wr_addr[1:0] != 2'h0) ?
                       `RESP_SLVERR : `RESP_OKAY;
      end else begin
        if (s_axi_awvalid && s_axi_awready) aw_held_reg <= 1'b1;
        if (s_axi_wvalid && s_axi_wready) w_held_reg <= 1'b1;
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port data and direction next values, including bit operations

  // the bit-op register acts on the whole byte of the chosen port register
  always @* begin
    port_a_data_next = port_a_data_reg;
    port_a_dir_next = port_a_dir_reg;
    port_e_data_next = port_e_data_reg;
    port_e_dir_next = port_e_dir_reg;
    if (wr_fire && wr_strb[0]) begin
      case (wr_addr)
        `OFS_PORT_A_DATA: port_a_data_next = wr_data[7:0];
        `OFS_PORT_A_DIR: port_a_dir_next = wr_data[7:0];
        `OFS_PORT_E_DATA: port_e_data_next = wr_data[7:0];
        `OFS_PORT_E_DIR: port_e_dir_next = wr_data[7:0];
        `OFS_BIT_OP: begin
          // read whole byte, change one bit, write the byte back
          case (wr_data[5:4])
            2'h0: port_a_data_next = bit_op(port_a_data_reg,
                                            wr_data[3:0]);
            2'h1: port_a_dir_next = bit_op(port_a_dir_reg,
                                           wr_data[3:0]);
            2'h2: port_e_data_next = bit_op(port_e_data_reg,
                                            wr_data[3:0]);
            default: port_e_dir_next = bit_op(port_e_dir_reg,
                                              wr_data[3:0]);
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register updates

  // selectors reset to zero; port registers reset to all ones
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_e_low_function_select_reg <= `RST_SEL;
      port_e_high_function_select_reg <= `RST_SEL;
      input_source_select_reg <= `RST_SEL;
      port_a_data_reg <= `RST_PORT;
      port_a_dir_reg <= `RST_PORT;
      port_e_data_reg <= `RST_PORT;
      port_e_dir_reg <= `RST_PORT;
      wake_en_reg <= 8'h00;
    end else begin
      port_a_data_reg <= port_a_data_next;
      port_a_dir_reg <= port_a_dir_next;
      port_e_data_reg <= port_e_data_next;
      port_e_dir_reg <= port_e_dir_next;
      if (wr_fire) begin
        case (wr_addr)
          `OFS_PE_LOW_SEL: port_e_low_function_select_reg <=
            lane0(port_e_low_function_select_reg, wr_data, wr_strb);
          `OFS_PE_HIGH_SEL: port_e_high_function_select_reg <=
            lane0(port_e_high_function_select_reg, wr_data, wr_strb);
          // bits missing in a variant ignore writes
          `OFS_IN_SRC_SEL: input_source_select_reg <=
            lane0(input_source_select_reg, wr_data, wr_strb) &
            IN_SRC_MASK;
          `OFS_WAKE_EN: wake_en_reg <=
            lane0(wake_en_reg, wr_data, wr_strb);
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi read path

  assign s_axi_arready = !s_axi_rvalid;

  // one-cycle answer; status shows live pins and the sleep flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr[5:0])
        `OFS_PE_LOW_SEL:
          s_axi_rdata <= {24'h000000, port_e_low_function_select_reg};
        `OFS_PE_HIGH_SEL:
          s_axi_rdata <= {24'h000000, port_e_high_function_select_reg};
        `OFS_IN_SRC_SEL:
          s_axi_rdata <= {24'h000000, input_source_select_reg};
        `OFS_PORT_A_DATA:
          s_axi_rdata <= {24'h000000, port_a_data_reg};
        `OFS_PORT_A_DIR:
          s_axi_rdata <= {24'h000000, port_a_dir_reg};
        `OFS_PORT_E_DATA:
          s_axi_rdata <= {24'h000000, port_e_data_reg};
        `OFS_PORT_E_DIR:
          s_axi_rdata <= {24'h000000, port_e_dir_reg};
        `OFS_BIT_OP:
          s_axi_rdata <= 32'h00000000;
        `OFS_WAKE_EN:
          s_axi_rdata <= {24'h000000, wake_en_reg};
        `OFS_STATUS:
          s_axi_rdata <= {15'h0000, sleeping, port_e_in, port_a_in};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port e output mux

  wire alt3;
  wire alt1;
  wire alt0;
  wire alt6;
  wire alt5;
  wire [7:0] alt_out;

  assign alt3 = port_e_low_function_select_reg[7:6] == `CODE_ALT;
  assign alt1 = port_e_low_function_select_reg[3:2] == `CODE_ALT;
  assign alt0 = port_e_low_function_select_reg[1:0] == `CODE_ALT;
  assign alt6 = port_e_high_function_select_reg[5:4] == `CODE_ALT;
  assign alt5 = port_e_high_function_select_reg[3:2] == `CODE_ALT;

  // pins 7, 4 and 2 ignore their selector codes entirely
  assign alt_out = {1'b0, alt6, alt5, 1'b0, alt3, 1'b0,
                    alt1, alt0};

  // direction bit high means input; data must be loaded first by software
  assign port_e_out = {port_e_data_reg[7],
                       alt6 ? standard_timer_output : port_e_data_reg[6],
                       alt5 ? standard_timer_output : port_e_data_reg[5],
                       port_e_data_reg[4],
                       alt3 ? compact_timer1_output : port_e_data_reg[3],
                       port_e_data_reg[2],
                       port_e_data_reg[1],
                       alt0 ? serial_tx : port_e_data_reg[0]};
  // receive pin is an input while attached to the serial port
  assign port_e_oe = {alt_out[7:2] | ~port_e_dir_reg[7:2],
                      ~alt1 & ~port_e_dir_reg[1],
                      alt0 | ~port_e_dir_reg[0]};
  assign port_a_out = port_a_data_reg;
  assign port_a_oe = ~port_a_dir_reg;

  assign compact_timer1_ext_clock = port_e_in[2];
  assign standard_timer_ext_clock = port_e_in[4];

  ////////////////////////////////////////////////////////////////////////
  // input-source selection

  sel_field_decode u_rx_sel (
    .code(input_source_select_reg[`ISS_RX_LSB+1:`ISS_RX_LSB]),
    .first_pin(port_c_pin2),
    .other_pin(port_e_in[1]),
    .picked(serial_rx_in)
  );

  sel_field_decode u_pt1_sel (
    .code(input_source_select_reg[`ISS_PT1_LSB+1:`ISS_PT1_LSB]),
    .first_pin(port_a_in[3]),
    .other_pin(port_a_in[4]),
    .picked(periodic_timer1_capture_in)
  );

  sel_field_decode u_pt0_sel (
    .code(input_source_select_reg[`ISS_PT0_LSB+1:`ISS_PT0_LSB]),
    .first_pin(port_a_in[0]),
    .other_pin(port_a_in[1]),
    .picked(periodic_timer0_capture_in)
  );

  sel_field_decode u_st_sel (
    .code(input_source_select_reg[`ISS_ST_LSB+1:`ISS_ST_LSB]),
    .first_pin(port_e_in[5]),
    .other_pin(port_e_in[6]),
    .picked(standard_timer_capture_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // port a wake-up

  wake_edge_detect #(
    .WIDTH(8)
  ) u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(port_a_in),
    .enable(wake_en_reg),
    .sleeping(sleeping),
    .wake(wake)
  );

endmodule // port_e_pin_mux

// [verilog/sel_field_decode.v]
// decodes one two-bit input-source field into a pin choice
// assumes the field comes straight from a register
module sel_field_decode (
  input wire [1:0] code,
  input wire first_pin,
  input wire other_pin,
  output wire picked
);
  // only code 00 keeps the first candidate; every other code takes the second
  assign picked = (code == 2'h0) ? first_pin : other_pin;
endmodule // sel_field_decode

// [verilog/wake_edge_detect.v]
// falling-edge wake detector for the eight port a pins
// assumes pins are synchronous to aclk and sleep comes from the power control
module wake_edge_detect #(
  parameter WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] pins,
  input wire [WIDTH-1:0] enable,
  input wire sleeping,
  output reg wake
);
  reg [WIDTH-1:0] prev_reg;

  // idle-high history: a pin that is low right after reset counts as a falling edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= {WIDTH{1'b1}};
      wake <= 1'b0;
    end else begin
      prev_reg <= pins;
      wake <= sleeping && |(prev_reg & ~pins & enable);
    end
  end
endmodule // wake_edge_detect
